// *** core/fsu_consts.svh ***
// constants of the fifo serial unit: register map, field positions, reset values, timing counts
// What this block does
// - Only asynchronous mode exists; bit timing is recovered afresh from each start bit.
// - Transmit and receive data each pass through their own sixteen-entry FIFO.
// - Request-to-send and clear-to-send modem pins sit beside the data pins.
// - Mode bit 6 picks 8 data bits when clear and 7 data bits when set.
// - Mode bit 5 adds a parity bit; mode bit 3 picks one stop bit when clear, two when set.
// - Eight frame formats: start, data, optional parity, one or two stops, 9 to 12 bit times.
// - Reception flags framing, parity, overrun and break, and shows FIFO-full and data-ready.
// - Software can read how many bytes sit in the transmit FIFO and in the receive FIFO.
// - Control bit 1 picks the serial clock: baud generator when clear, external pin when set.
// - With the internal clock chosen the external clock pin is ignored.
// - A frame opens with one low start bit, then data least significant bit first.
// - Between frames the transmitter holds the line high.
// - With two stop bits the receiver checks only the first one.
// - With modem control on, clear-to-send high lets the frame finish then idles; low resumes.
`ifndef FSU_CONSTS_SVH
`define FSU_CONSTS_SVH

`define FSU_ADDR_W        5
`define FSU_OFF_MODE      5'h00
`define FSU_OFF_CTRL      5'h04
`define FSU_OFF_TXDATA    5'h08
`define FSU_OFF_RXDATA    5'h0C
`define FSU_OFF_STATUS    5'h10
`define FSU_OFF_LEVEL     5'h14
`define FSU_OFF_DIVISOR   5'h18

`define FSU_MODE_CHR      6
`define FSU_MODE_PE       5
`define FSU_MODE_ODD      4
`define FSU_MODE_STOP     3
`define FSU_CTRL_TXEN     0
`define FSU_CTRL_CLKSEL   1
`define FSU_CTRL_RXEN     2
`define FSU_CTRL_MODEM    3

`define FSU_ST_FER        0
`define FSU_ST_PER        1
`define FSU_ST_ORER       2
`define FSU_ST_BRK        3
`define FSU_ST_RFULL      4
`define FSU_ST_RDR        5
`define FSU_ST_TEND       6

`define FSU_MODE_RESET    8'h00
`define FSU_CTRL_RESET    8'h00
`define FSU_DIV_RESET     16'h0035
`define FSU_OVS_LAST      4'hF
`define FSU_OVS_MID       4'h7
`define FSU_RTS_LEVEL     5'h0F
`define FSU_LEVEL_RX_LSB  8

`endif

// *** core/fsu_pkg.sv ***
// types shared by the fifo serial unit
package fsu_pkg;
    typedef enum logic [2:0] {FSU_TX_IDLE, FSU_TX_START, FSU_TX_DATA, FSU_TX_PAR, FSU_TX_STOP} fsu_tx_state_t;
    typedef enum logic [2:0] {FSU_RX_IDLE, FSU_RX_START, FSU_RX_DATA, FSU_RX_PAR, FSU_RX_STOP} fsu_rx_state_t;
endpackage

// *** core/fsu_top.sv ***
// fifo serial unit: buffering fifo and the uart core with its avalon-mm register slave
`include "fsu_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module fsu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0]           mem_reg [DEPTH];
    logic [AW-1:0]              wr_reg;
    logic [AW-1:0]              rd_reg;
    logic [CW-1:0]              cnt_reg;
    wire                        do_push = in_valid & in_ready;
    wire                        do_pop  = out_valid & out_ready;

    assign in_ready  = cnt_reg != CW'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem_reg[rd_reg];
    assign count     = cnt_reg;

    always_ff @(posedge clk) begin
        if (do_push)
            mem_reg[wr_reg] <= in_data;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_push)
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            if (do_pop)
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
        end
    end

    a_fifo_bound : assert property (@(posedge clk) disable iff (rst) cnt_reg <= DEPTH)
        else $error("fifo count above depth");
endmodule // fsu_fifo

module fsu_top #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic [`FSU_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   receive_data_pin,
    output logic                        transmit_data_pin,
    input  wire logic                   external_serial_clock_pin,
    input  wire logic                   clear_to_send_pin_n,
    output logic                        request_to_send_pin_n
);
    import fsu_pkg::*;
    localparam int CW = $clog2(FIFO_DEPTH+1);

    logic [7:0]    mode_reg;
    logic [7:0]    ctrl_reg;
    logic [15:0]   div_reg;
    logic [3:0]    err_reg;
    logic          ack_reg;
    logic [31:0]   rdata_reg;
    logic [15:0]   div_cnt_reg;
    logic          ext_q_reg;
    logic          rts_reg;
    fsu_tx_state_t t_state_reg;
    logic [3:0]    t_os_reg;
    logic [2:0]    t_bit_reg;
    logic [7:0]    t_shift_reg;
    logic          t_par_reg;
    logic          txd_reg;
    fsu_rx_state_t r_state_reg;
    logic [3:0]    r_os_reg;
    logic [2:0]    r_bit_reg;
    logic [7:0]    r_shift_reg;
    logic          r_pbit_reg;

    // mode and control fields
    wire       chr7    = mode_reg[`FSU_MODE_CHR];
    wire       par_en  = mode_reg[`FSU_MODE_PE];
    wire       odd     = mode_reg[`FSU_MODE_ODD];
    wire       stop2   = mode_reg[`FSU_MODE_STOP];
    wire       tx_en   = ctrl_reg[`FSU_CTRL_TXEN];
    wire       rx_en   = ctrl_reg[`FSU_CTRL_RXEN];
    wire       clksel  = ctrl_reg[`FSU_CTRL_CLKSEL];
    wire       modem   = ctrl_reg[`FSU_CTRL_MODEM];
    wire [2:0] last_bit = chr7 ? 3'h6 : 3'h7;

    // bus slave: one wait cycle per access, more while the transmit fifo is full
    wire req      = avs_read | avs_write;
    wire hit_tx   = avs_address == `FSU_OFF_TXDATA;
    wire hit_rx   = avs_address == `FSU_OFF_RXDATA;
    wire tx_in_ready;
    wire stall    = avs_write & hit_tx & ~tx_in_ready;
    wire done     = req & ack_reg & ~stall;
    wire wr_done  = done & avs_write;
    assign avs_waitrequest = req & ~(ack_reg & ~stall);
    assign avs_readdata    = rdata_reg;

    // serial clock: one 16x enable pulse from the divider or from the pin
    wire int_tick = div_cnt_reg >= div_reg;
    wire ext_tick = external_serial_clock_pin & ~ext_q_reg;
    wire tick     = clksel ? ext_tick : int_tick;

    // fifo wiring
    wire          tx_out_valid;
    wire [7:0]    tx_out_data;
    wire [CW-1:0] tx_count;
    wire          rx_in_ready;
    wire          rx_out_valid;
    wire [7:0]    rx_out_data;
    wire [CW-1:0] rx_count;
    wire          cts_hold = modem & clear_to_send_pin_n;
    wire          tx_pop   = (t_state_reg == FSU_TX_IDLE) & tx_en & tx_out_valid & ~cts_hold;
    wire          rx_pop   = done & avs_read & hit_rx;

    fsu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk       (core_clk),
        .rst       (rst),
        .in_valid  (wr_done & hit_tx),
        .in_ready  (tx_in_ready),
        .in_data   (avs_writedata[7:0]),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_out_data),
        .count     (tx_count)
    );

    // receive frame check
    wire       r_sample  = tick & (r_os_reg == `FSU_OVS_LAST);
    wire       r_done    = (r_state_reg == FSU_RX_STOP) & r_sample;
    wire [7:0] r_data    = chr7 ? {1'b0, r_shift_reg[7:1]} : r_shift_reg;
    wire       r_par_bad = par_en & ((^r_data ^ odd) != r_pbit_reg);
    wire       r_break   = (r_data == 8'h00) & ~(par_en & r_pbit_reg) & ~receive_data_pin;
    wire       r_ovr     = r_done & ~r_break & ~rx_in_ready;
    wire       rx_push   = r_done & ~r_break & rx_in_ready;

    fsu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk       (core_clk),
        .rst       (rst),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (r_data),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out_data),
        .count     (rx_count)
    );

    // error flags: hardware set wins over a software clear written in the same cycle
    wire [3:0] err_set = {r_done & r_break, r_ovr,
                          r_done & ~r_break & r_par_bad,
                          r_done & ~r_break & ~receive_data_pin};
    wire [3:0] err_clr = (wr_done && avs_address == `FSU_OFF_STATUS) ? ~avs_writedata[3:0] : 4'h0;
    wire [3:0] err_next = (err_reg & ~err_clr) | err_set;
    wire       tend     = (t_state_reg == FSU_TX_IDLE) & ~tx_out_valid;
    wire [7:0] status   = {1'b0, tend, rx_out_valid, ~rx_in_ready, err_reg};

    // read mux
    logic [31:0] rmux;
    always_comb begin
        case (avs_address)
            `FSU_OFF_MODE:    rmux = {24'h0, mode_reg};
            `FSU_OFF_CTRL:    rmux = {24'h0, ctrl_reg};
            `FSU_OFF_RXDATA:  rmux = {24'h0, rx_out_valid ? rx_out_data : 8'h00};
            `FSU_OFF_STATUS:  rmux = {24'h0, status};
            `FSU_OFF_LEVEL:   rmux = 32'(rx_count) << `FSU_LEVEL_RX_LSB | 32'(tx_count);
            `FSU_OFF_DIVISOR: rmux = {16'h0, div_reg};
            default:          rmux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
            mode_reg  <= `FSU_MODE_RESET;
            ctrl_reg  <= `FSU_CTRL_RESET;
            div_reg   <= `FSU_DIV_RESET;
            err_reg   <= 4'h0;
        end else begin
            ack_reg <= req & ~done;
            err_reg <= err_next;
            if (req & ~ack_reg)
                rdata_reg <= rmux;
            if (wr_done && avs_address == `FSU_OFF_MODE)
                mode_reg <= avs_writedata[7:0];
            if (wr_done && avs_address == `FSU_OFF_CTRL)
                ctrl_reg <= avs_writedata[7:0];
            if (wr_done && avs_address == `FSU_OFF_DIVISOR)
                div_reg <= avs_writedata[15:0];
        end
    end

    // clock sources and modem output
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_cnt_reg <= 16'h0;
            ext_q_reg   <= 1'b0;
            rts_reg     <= 1'b0;
        end else begin
            div_cnt_reg <= int_tick ? 16'h0 : div_cnt_reg + 16'h1;
            ext_q_reg   <= external_serial_clock_pin;
            rts_reg     <= modem & (rx_count >= CW'(`FSU_RTS_LEVEL));
        end
    end
    assign request_to_send_pin_n = rts_reg;

    // transmitter
    always_ff @(posedge core_clk) begin
        if (rst || !tx_en) begin
            t_state_reg <= FSU_TX_IDLE;
            t_os_reg    <= 4'h0;
            t_bit_reg   <= 3'h0;
            t_shift_reg <= 8'h0;
            t_par_reg   <= 1'b0;
            txd_reg     <= 1'b1;
        end else if (tx_pop) begin
            t_state_reg <= FSU_TX_START;
            t_os_reg    <= 4'h0;
            t_shift_reg <= tx_out_data;
            t_par_reg   <= ^(chr7 ? {1'b0, tx_out_data[6:0]} : tx_out_data) ^ odd;
            txd_reg     <= 1'b0;
        end else if (tick && t_state_reg != FSU_TX_IDLE) begin
            t_os_reg <= t_os_reg + 4'h1;
            if (t_os_reg == `FSU_OVS_LAST) begin
                case (t_state_reg)
                    FSU_TX_START: begin
                        t_state_reg <= FSU_TX_DATA;
                        t_bit_reg   <= 3'h0;
                        txd_reg     <= t_shift_reg[0];
                        t_shift_reg <= t_shift_reg >> 1;
                    end
                    FSU_TX_DATA: begin
                        if (t_bit_reg == last_bit) begin
                            t_state_reg <= par_en ? FSU_TX_PAR : FSU_TX_STOP;
                            txd_reg     <= par_en ? t_par_reg : 1'b1;
                            t_bit_reg   <= 3'h0;
                        end else begin
                            t_bit_reg   <= t_bit_reg + 3'h1;
                            txd_reg     <= t_shift_reg[0];
                            t_shift_reg <= t_shift_reg >> 1;
                        end
                    end
                    FSU_TX_PAR: begin
                        t_state_reg <= FSU_TX_STOP;
                        txd_reg     <= 1'b1;
                    end
                    FSU_TX_STOP: begin
                        if (t_bit_reg == {2'b0, stop2})
                            t_state_reg <= FSU_TX_IDLE;
                        t_bit_reg <= t_bit_reg + 3'h1;
                    end
                    default: t_state_reg <= FSU_TX_IDLE;
                endcase
            end
        end
    end
    assign transmit_data_pin = txd_reg;

    // receiver: a held overrun flag stops further reception until cleared
    always_ff @(posedge core_clk) begin
        if (rst || !rx_en) begin
            r_state_reg <= FSU_RX_IDLE;
            r_os_reg    <= 4'h0;
            r_bit_reg   <= 3'h0;
            r_shift_reg <= 8'h0;
            r_pbit_reg  <= 1'b0;
        end else if (r_state_reg == FSU_RX_IDLE) begin
            if (!receive_data_pin && !err_reg[`FSU_ST_ORER]) begin
                r_state_reg <= FSU_RX_START;
                r_os_reg    <= 4'h0;
            end
        end else if (tick) begin
            r_os_reg <= r_os_reg + 4'h1;
            case (r_state_reg)
                FSU_RX_START: begin
                    if (r_os_reg == `FSU_OVS_MID) begin
                        r_state_reg <= receive_data_pin ? FSU_RX_IDLE : FSU_RX_DATA;
                        r_os_reg    <= 4'h0;
                        r_bit_reg   <= 3'h0;
                    end
                end
                FSU_RX_DATA: begin
                    if (r_sample) begin
                        r_shift_reg <= {receive_data_pin, r_shift_reg[7:1]};
                        r_bit_reg   <= r_bit_reg + 3'h1;
                        if (r_bit_reg == last_bit)
                            r_state_reg <= par_en ? FSU_RX_PAR : FSU_RX_STOP;
                    end
                end
                FSU_RX_PAR: begin
                    if (r_sample) begin
                        r_pbit_reg  <= receive_data_pin;
                        r_state_reg <= FSU_RX_STOP;
                    end
                end
                FSU_RX_STOP: begin
                    if (r_sample)
                        r_state_reg <= FSU_RX_IDLE;
                end
                default: r_state_reg <= FSU_RX_IDLE;
            endcase
        end
    end

    sequence s_frame_opens;
        tx_pop ##1 !transmit_data_pin;
    endsequence
    sequence s_word_answered;
        req & ~ack_reg & ~stall ##1 ~avs_waitrequest;
    endsequence

    a_tx_mark_idle : assert property (@(posedge core_clk) disable iff (rst)
        $past(t_state_reg == FSU_TX_IDLE && !tx_pop) |-> transmit_data_pin)
        else $error("line not at mark while idle");
    a_tx_start_low : assert property (@(posedge core_clk) disable iff (rst)
        tx_pop |-> s_frame_opens)
        else $error("frame did not open with a low start bit");
    a_cts_holds_tx : assert property (@(posedge core_clk) disable iff (rst)
        (cts_hold && t_state_reg == FSU_TX_IDLE) |=> t_state_reg == FSU_TX_IDLE)
        else $error("frame started while clear-to-send high");
    a_rts_on_full : assert property (@(posedge core_clk) disable iff (rst)
        (modem && rx_count >= CW'(`FSU_RTS_LEVEL)) |=> request_to_send_pin_n)
        else $error("request-to-send not raised near full");
    a_clk_internal : assert property (@(posedge core_clk) disable iff (rst)
        !clksel |-> (tick == int_tick))
        else $error("external pin used while internal clock chosen");
    a_overrun_drop : assert property (@(posedge core_clk) disable iff (rst)
        r_ovr |-> !rx_push ##1 err_reg[`FSU_ST_ORER])
        else $error("overrun not flagged or data pushed");
    a_parity_flag : assert property (@(posedge core_clk) disable iff (rst)
        (r_done && !r_break && r_par_bad) |=> err_reg[`FSU_ST_PER])
        else $error("parity mismatch not flagged");
    a_level_report : assert property (@(posedge core_clk) disable iff (rst)
        (req && !ack_reg && avs_address == `FSU_OFF_LEVEL) |=> rdata_reg[4:0] == 5'($past(tx_count)))
        else $error("level register does not show transmit count");
    a_bus_answer : assert property (@(posedge core_clk) disable iff (rst)
        (req & ~ack_reg & ~stall) |-> s_word_answered)
        else $error("bus access not answered after one wait cycle");
endmodule // fsu_top

`default_nettype wire

// *** tb/fsu_remote.sv ***
// remote serial station on the line side of the fifo serial unit
`timescale 1ns/1ps
`default_nettype none

module fsu_remote (
    input  wire logic core_clk,
    input  wire logic line_in,
    output logic      line_out,
    output logic      cts_n,
    output logic      ext_clk
);
    int         bit_cyc  = 32;
    logic       cts_hold = 1'b0;
    logic [1:0] ext_div  = 2'h0;

    initial line_out = 1'b1;
    assign cts_n = cts_hold;
    // the 16x clock runs free: stopping it in operation is not allowed
    assign ext_clk = ext_div[1];
    always @(posedge core_clk) begin
        ext_div <= ext_div + 2'h1;
    end

    // a zero first stop is cut to 3/4 bit so the receiver cannot mistake it for a new start
    task automatic send_frame(input logic [7:0] d, input int nd, input logic pe, input logic odd,
                              input int ns, input logic flip, input logic [1:0] stops);
        logic [11:0] f;
        int          n;
        f = 12'hFFF;
        f[0] = 1'b0;
        for (int i = 0; i < nd; i++) f[1 + i] = d[i];
        n = 1 + nd;
        if (pe) begin
            f[n] = ^(d & (nd == 7 ? 8'h7F : 8'hFF)) ^ odd ^ flip;
            n++;
        end
        f[n] = stops[0];
        if (ns == 2) f[n + 1] = stops[1];
        n += ns;
        for (int i = 0; i < n; i++) begin
            line_out <= f[i];
            repeat ((i == n - ns && !f[i]) ? bit_cyc * 3 / 4 : bit_cyc) @(posedge core_clk);
        end
        line_out <= 1'b1;
        @(posedge core_clk);
    endtask

    // timing is taken afresh from each start edge
    task automatic recv_frame(input int nd, input logic pe, input int ns,
                              output logic [7:0] d, output logic par, output logic [1:0] st);
        d = 8'h00;
        par = 1'b0;
        st = 2'h0;
        wait (line_in === 1'b0);
        repeat (bit_cyc / 2) @(posedge core_clk);
        for (int i = 0; i < nd; i++) begin
            repeat (bit_cyc) @(posedge core_clk);
            d[i] = line_in;
        end
        if (pe) begin
            repeat (bit_cyc) @(posedge core_clk);
            par = line_in;
        end
        for (int i = 0; i < ns; i++) begin
            repeat (bit_cyc) @(posedge core_clk);
            st[i] = line_in;
        end
    endtask
endmodule  // fsu_remote

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the fifo serial unit
`include "fsu_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                   core_clk;
    logic                   rst = 1'b1;
    logic [`FSU_ADDR_W-1:0] avs_address = '0;
    logic                   avs_read = 1'b0;
    logic                   avs_write = 1'b0;
    logic [31:0]            avs_writedata = '0;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic                   rx_line;
    logic                   tx_line;
    logic                   ext_clk;
    logic                   cts_n;
    logic                   rts_n;
    int                     miscompares = 0;
    int                     checks_done = 0;
    int                     cycles = 0;
    logic [31:0]            rd;
    logic [7:0]             b;
    logic [7:0]             got;
    logic [7:0]             q[$];
    logic                   par;
    logic [1:0]             st;
    logic [3:0]             fmt;
    time                    t0;
    logic [31:0]            reg_exp [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h40, 32'h0, 32'h35, 32'h0};

    fsu_top fsu_top_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .receive_data_pin(rx_line), .transmit_data_pin(tx_line),
        .external_serial_clock_pin(ext_clk), .clear_to_send_pin_n(cts_n), .request_to_send_pin_n(rts_n));
    fsu_remote fsu_remote_i (.core_clk(core_clk), .line_in(tx_line), .line_out(rx_line), .cts_n(cts_n),
        .ext_clk(ext_clk));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // the request stands until the rising edge that sees waitrequest low; read data is taken there
    task automatic bus(input logic wr, input logic [`FSU_ADDR_W-1:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdchk(input logic [`FSU_ADDR_W-1:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    task automatic cfg(input logic [31:0] m, input logic [31:0] c);
        bus(1'b1, `FSU_OFF_CTRL, 32'h0);
        bus(1'b1, `FSU_OFF_MODE, m);
        bus(1'b1, `FSU_OFF_CTRL, c);
    endtask

    function automatic logic exp_par(input logic [7:0] d, input logic chr, input logic odd);
        return ^(d & {~chr, 7'h7F}) ^ odd;
    endfunction

    initial begin
        void'($urandom(32'hD827));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(tx_line, 1'b1);
        check(rts_n, 1'b0);
        foreach (reg_exp[i]) rdchk(5'(i * 4), reg_exp[i]);
        bus(1'b1, `FSU_OFF_DIVISOR, 32'hFFFF0001);
        rdchk(`FSU_OFF_DIVISOR, 32'h1);
        for (int f = 0; f < 8; f++) begin
            fmt = {f[2], f[1], 1'($urandom), f[0]};
            cfg({25'h0, fmt, 3'h0}, 32'h5);
            b = 8'($urandom);
            bus(1'b1, `FSU_OFF_TXDATA, {24'h0, b});
            fsu_remote_i.recv_frame(fmt[3] ? 7 : 8, fmt[2], fmt[0] ? 2 : 1, got, par, st);
            check(got, b & {~fmt[3], 7'h7F});
            if (fmt[2]) check(par, exp_par(b, fmt[3], fmt[1]));
            check(st, fmt[0] ? 2'h3 : 2'h1);
            b = 8'($urandom);
            fsu_remote_i.send_frame(b, fmt[3] ? 7 : 8, fmt[2], fmt[1], fmt[0] ? 2 : 1, 1'b0, 2'h3);
            check(tx_line, 1'b1);
            rdchk(`FSU_OFF_RXDATA, {24'h0, b & {~fmt[3], 7'h7F}});
            rdchk(`FSU_OFF_STATUS, 32'h40);
        end
        cfg(32'h0, 32'hD);
        for (int i = 0; i < 17; i++) begin
            b = 8'($urandom);
            if (i < 16) q.push_back(b);
            fsu_remote_i.send_frame(b, 8, 1'b0, 1'b0, 1, 1'b0, 2'h3);
            if (i == 13) check(rts_n, 1'b0);
            if (i == 14) check(rts_n, 1'b1);
            if (i == 15) rdchk(`FSU_OFF_LEVEL, 32'h1000);
        end
        rdchk(`FSU_OFF_STATUS, 32'h74);
        while (q.size() > 0) rdchk(`FSU_OFF_RXDATA, {24'h0, q.pop_front()});
        bus(1'b1, `FSU_OFF_STATUS, 32'h0);
        rdchk(`FSU_OFF_STATUS, 32'h40);
        check(rts_n, 1'b0);
        // transmit fifo filled while the far side holds clear-to-send off
        fsu_remote_i.cts_hold <= 1'b1;
        cfg(32'h0, 32'hD);
        for (int i = 0; i < 17; i++) q.push_back(8'($urandom));
        for (int i = 0; i < 16; i++) bus(1'b1, `FSU_OFF_TXDATA, {24'h0, q[i]});
        check(tx_line, 1'b1);
        rdchk(`FSU_OFF_LEVEL, 32'h10);
        fork
            begin
                t0 = $time;
                bus(1'b1, `FSU_OFF_TXDATA, {24'h0, q[16]});
                check(($time - t0) > 400 ? 32'h1 : 32'h0, 32'h1);
            end
            begin
                repeat (100) @(posedge core_clk);
                fsu_remote_i.cts_hold <= 1'b0;
                for (int i = 0; i < 17; i++) begin
                    fsu_remote_i.recv_frame(8, 1'b0, 1, got, par, st);
                    check(got, q.pop_front());
                end
            end
        join
        fsu_remote_i.bit_cyc = 64;
        cfg(32'h0, 32'h7);
        b = 8'($urandom);
        bus(1'b1, `FSU_OFF_TXDATA, {24'h0, b});
        fsu_remote_i.recv_frame(8, 1'b0, 1, got, par, st);
        check(got, b);
        fsu_remote_i.send_frame(~b, 8, 1'b0, 1'b0, 1, 1'b0, 2'h3);
        rdchk(`FSU_OFF_RXDATA, {24'h0, ~b});
        fsu_remote_i.bit_cyc = 32;
        cfg(32'h28, 32'h5);
        b = 8'($urandom);
        fsu_remote_i.send_frame(b, 8, 1'b1, 1'b0, 2, 1'b1, 2'h3);
        rdchk(`FSU_OFF_RXDATA, {24'h0, b});
        rdchk(`FSU_OFF_STATUS, 32'h42);
        cfg(32'h0, 32'h5);
        b = 8'($urandom) | 8'h01;
        fsu_remote_i.send_frame(b, 8, 1'b0, 1'b0, 1, 1'b0, 2'h0);
        rdchk(`FSU_OFF_RXDATA, {24'h0, b});
        rdchk(`FSU_OFF_STATUS, 32'h43);
        bus(1'b1, `FSU_OFF_STATUS, 32'h0);
        fsu_remote_i.send_frame(8'h00, 8, 1'b0, 1'b0, 1, 1'b0, 2'h0);
        rdchk(`FSU_OFF_STATUS, 32'h48);
        rdchk(`FSU_OFF_LEVEL, 32'h0);
        stop_test();
    end
endmodule  // tb

`default_nettype wire
